// ===== src/ssm_regs.svh
// register numbers, field positions, reset values and encodings for the special register block
// Overview of operation
// - software reads of the execution state register always return zero
// - software writes to the execution state register are ignored
// - compact instruction state bit sits at bit 24
// - bits 26:25 and 15:10 hold continuation or conditional block state, not both
// - interrupt during multiple transfer records next register in bits 15:12
// - after service the multiple transfer resumes from the register in bits 15:12
// - with continuation state held, bits 26:25 and 11:10 are zero
// - conditional block covers up to four instructions after the if-then
// - compact bit cleared only by branch exchange, pop pc, status restore, vector bit 0
// - executing with compact bit zero raises a fault
// - priority mask bit 0 set blocks all configurable priority exceptions
// - fault mask bit 0 set blocks all exceptions except nmi
// - fault mask clears on exit from any handler other than nmi
// - nonzero base priority blocks exceptions with priority value at or above it
// - base priority is eight bits; unimplemented low bits read zero
// - masks written by move to special; two masks also by change state
// - control bit 2 flags active floating point context for exception stacking
// - control bit 1 selects stack; reads zero and ignores writes in handler mode
// - control bit 0 set makes thread mode unprivileged
// - exception entry clears control bits 2:1; exception return sets them from the return code
// - thread uses main stack by default; process stack on write or return
// - masks and control reset to zero and need privileged access
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH
`define SSM_SEL_EXEC        3'h0
`define SSM_SEL_CFG_MASK        3'h1
`define SSM_SEL_ALL_MASK        3'h2
`define SSM_SEL_BASE_THR        3'h3
`define SSM_SEL_CONTROL         3'h4
`define SSM_EXEC_T_BIT          24
`define SSM_EXEC_RESET          32'h0100_0000
`define SSM_CTRL_FP_ACTIVE_BIT  2
`define SSM_CTRL_STACK_SEL_BIT  1
`define SSM_CTRL_UNPRIV_BIT     0
`define SSM_ZERO32              32'h0000_0000
`define SSM_NMI_NUM             9'h002
`define SSM_COND_LEN_MAX        3'h4
`endif

// ===== src/ssm_pkg.sv
// types shared by the special register block
`default_nettype none
package ssm_pkg;
    typedef struct packed {
        logic       valid;
        logic [2:0] sel;
        logic [31:0] data;
    } ssm_wr_t;
    typedef struct packed {
        logic       valid;
        logic       to_handler;
        logic [8:0] exc_num;
        logic       ret_thread;
        logic       ret_proc_stack;
        logic       ret_fp;
        logic [31:0] status;
    } ssm_exc_t;
    typedef enum logic [1:0] {
        SSM_ST_NORMAL,
        SSM_ST_COND,
        SSM_ST_CONT
    } ssm_exec_mode_t;
endpackage
`default_nettype wire

// ===== src/ssm_special_regs.sv
// special status, mask and control registers beside the pipeline
`include "ssm_regs.svh"
`default_nettype none
module ssm_special_regs #(
    parameter int PRIO_BITS = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              privileged,
    input  wire logic              handler_mode,
    input  wire ssm_pkg::ssm_wr_t  sw_wr,
    input  wire logic [2:0]        sw_rd_sel,
    input  wire logic              chg_state_valid,
    input  wire logic              chg_state_disable,
    input  wire logic              chg_state_cfg_mask,
    input  wire logic              chg_state_all_mask,
    input  wire logic              multi_suspend,
    input  wire logic [3:0]        multi_next_reg,
    input  wire logic              multi_resume,
    input  wire logic              cond_blk_start,
    input  wire logic [7:0]        cond_blk_state,
    input  wire logic              cond_blk_advance,
    input  wire logic              t_clear_valid,
    input  wire logic              t_clear_value,
    input  wire logic              exec_issue,
    input  wire ssm_pkg::ssm_exc_t exc,
    input  wire logic [7:0]        req_priority,
    input  wire logic              req_configurable,
    input  wire logic              req_is_nmi,
    output logic [31:0]            sw_rd_data,
    output logic [31:0]            exec_state,
    output logic [3:0]             resume_reg,
    output logic                   resume_valid,
    output logic                   t_fault,
    output logic                   exc_blocked,
    output logic                   use_process_stack,
    output logic                   thread_unpriv_o,
    output logic                   fp_preserve
);
    logic [31:0] exec_q, exec_d;
    logic        cfg_mask_q, cfg_mask_d;
    logic        all_mask_q, all_mask_d;
    logic [7:0]  base_thr_q, base_thr_d;
    logic [2:0]  ctrl_q, ctrl_d;
    logic [31:0] rd_d;
    logic [3:0]  resume_q;
    logic        resume_v_q, tf_q, blk_q, ps_q, np_q, fpp_q;
    logic [2:0]  cond_cnt_q, cond_cnt_d;

    // unimplemented low-order priority bits never store
    localparam logic [7:0] PRIO_KEEP = 8'(8'hFF << (8 - PRIO_BITS));

    wire wr_ok      = sw_wr.valid && privileged;
    wire wr_cm      = wr_ok && sw_wr.sel == `SSM_SEL_CFG_MASK;
    wire wr_am      = wr_ok && sw_wr.sel == `SSM_SEL_ALL_MASK;
    wire wr_bt      = wr_ok && sw_wr.sel == `SSM_SEL_BASE_THR;
    wire wr_ct      = wr_ok && sw_wr.sel == `SSM_SEL_CONTROL;
    wire chg_ok     = chg_state_valid && privileged;
    wire exc_entry  = exc.valid && exc.to_handler;
    wire exc_ret    = exc.valid && !exc.to_handler;
    wire ret_nonnmi = exc_ret && exc.exc_num != `SSM_NMI_NUM;
    wire t_bit      = exec_q[`SSM_EXEC_T_BIT];
    // resume register is latched at the resume strobe, since exec state clears at that edge
    wire [3:0] resume_d = multi_resume ? exec_q[15:12] : resume_q;

    // exec state: t bit plus shared continuation / conditional block field
    always_comb begin
        exec_d     = exec_q;
        cond_cnt_d = cond_cnt_q;
        if (multi_suspend) begin
            // continuation form keeps bits 26:25 and 11:10 clear
            exec_d[26:25] = 2'h0;
            exec_d[11:10] = 2'h0;
            exec_d[15:12] = multi_next_reg;
            cond_cnt_d    = 3'h0;
        end else if (cond_blk_start) begin
            exec_d[26:25] = cond_blk_state[1:0];
            exec_d[15:10] = cond_blk_state[7:2];
            cond_cnt_d    = `SSM_COND_LEN_MAX;
        end else if (multi_resume) begin
            exec_d[26:25] = 2'h0;
            exec_d[15:10] = 6'h00;
        end else if (cond_blk_advance && cond_cnt_q != 3'h0) begin
            cond_cnt_d = 3'(cond_cnt_q - 3'h1);
            if (cond_cnt_q == 3'h1) begin
                exec_d[26:25] = 2'h0;
                exec_d[15:10] = 6'h00;
            end else begin
                exec_d[14:10] = {exec_q[13:10], exec_q[26]};
                exec_d[26:25] = {exec_q[25], 1'b0};
            end
        end
        if (exc_ret) begin
            exec_d[`SSM_EXEC_T_BIT] = exc.status[`SSM_EXEC_T_BIT];
            exec_d[26:25]           = exc.status[26:25];
            exec_d[15:10]           = exc.status[15:10];
        end else if (t_clear_valid) begin
            exec_d[`SSM_EXEC_T_BIT] = t_clear_value;
        end
        exec_d[31:27] = 5'h00;
        exec_d[23:16] = 8'h00;
        exec_d[9:0]   = 10'h000;
    end

    always_comb begin
        cfg_mask_d = cfg_mask_q;
        all_mask_d = all_mask_q;
        base_thr_d = base_thr_q;
        ctrl_d     = ctrl_q;
        if (wr_cm) cfg_mask_d = sw_wr.data[0];
        if (wr_am) all_mask_d = sw_wr.data[0];
        if (wr_bt) base_thr_d = sw_wr.data[7:0] & PRIO_KEEP;
        if (chg_ok && chg_state_cfg_mask) cfg_mask_d = chg_state_disable;
        if (chg_ok && chg_state_all_mask) all_mask_d = chg_state_disable;
        if (ret_nonnmi) all_mask_d = 1'b0;
        if (wr_ct) begin
            ctrl_d[`SSM_CTRL_UNPRIV_BIT]    = sw_wr.data[0];
            ctrl_d[`SSM_CTRL_FP_ACTIVE_BIT] = sw_wr.data[2];
            if (!handler_mode) ctrl_d[`SSM_CTRL_STACK_SEL_BIT] = sw_wr.data[1];
        end
        if (exc_entry) begin
            ctrl_d[`SSM_CTRL_STACK_SEL_BIT] = 1'b0;
            ctrl_d[`SSM_CTRL_FP_ACTIVE_BIT] = 1'b0;
        end else if (exc_ret) begin
            ctrl_d[`SSM_CTRL_STACK_SEL_BIT] = exc.ret_thread && exc.ret_proc_stack;
            ctrl_d[`SSM_CTRL_FP_ACTIVE_BIT] = exc.ret_fp;
        end
    end

    // software reads: exec state always zero; stack_select hidden in handler mode
    always_comb begin
        rd_d = `SSM_ZERO32;
        if (privileged) begin
            case (sw_rd_sel)
                `SSM_SEL_EXEC:      rd_d = `SSM_ZERO32;
                `SSM_SEL_CFG_MASK:  rd_d = {31'h0, cfg_mask_q};
                `SSM_SEL_ALL_MASK:  rd_d = {31'h0, all_mask_q};
                `SSM_SEL_BASE_THR:  rd_d = {24'h0, base_thr_q};
                `SSM_SEL_CONTROL:   rd_d = {29'h0, ctrl_q[2], ctrl_q[1] & ~handler_mode, ctrl_q[0]};
                default:            rd_d = `SSM_ZERO32;
            endcase
        end
    end

    // lower priority value is more urgent, so block at or above threshold
    wire bp_block = base_thr_q != 8'h00 && req_priority >= base_thr_q;
    wire blk_d    = (all_mask_q && !req_is_nmi)
                  || (cfg_mask_q && req_configurable)
                  || (bp_block && req_configurable);

    // exec state is not a write target; only pipeline events and exception return change it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exec_q     <= `SSM_EXEC_RESET;
            cond_cnt_q <= 3'h0;
        end else begin
            exec_q     <= exec_d;
            cond_cnt_q <= cond_cnt_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_mask_q <= 1'b0;
            all_mask_q <= 1'b0;
            base_thr_q <= 8'h00;
            ctrl_q     <= 3'h0;
        end else begin
            cfg_mask_q <= cfg_mask_d;
            all_mask_q <= all_mask_d;
            base_thr_q <= base_thr_d;
            ctrl_q     <= ctrl_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_rd_data <= `SSM_ZERO32;
            resume_q   <= 4'h0;
            resume_v_q <= 1'b0;
            tf_q       <= 1'b0;
            blk_q      <= 1'b0;
            ps_q       <= 1'b0;
            np_q       <= 1'b0;
            fpp_q      <= 1'b0;
        end else begin
            sw_rd_data <= rd_d;
            resume_q   <= resume_d;
            resume_v_q <= multi_resume;
            tf_q       <= exec_issue && !t_bit;
            blk_q      <= blk_d;
            ps_q       <= ctrl_q[`SSM_CTRL_STACK_SEL_BIT] && !handler_mode;
            np_q       <= ctrl_q[`SSM_CTRL_UNPRIV_BIT];
            fpp_q      <= ctrl_q[`SSM_CTRL_FP_ACTIVE_BIT];
        end
    end

    assign exec_state        = exec_q;
    assign resume_reg        = resume_q;
    assign resume_valid      = resume_v_q;
    assign t_fault           = tf_q;
    assign exc_blocked       = blk_q;
    assign use_process_stack = ps_q;
    assign thread_unpriv_o   = np_q;
    assign fp_preserve       = fpp_q;

    property p_exec_read_zero;
        @(posedge clk) disable iff (rst) ##1 $past(sw_rd_sel) == `SSM_SEL_EXEC |-> sw_rd_data == `SSM_ZERO32;
    endproperty
    a_exec_read_zero: assert property (p_exec_read_zero) else $error("exec state read not zero");

    property p_suspend_records;
        @(posedge clk) disable iff (rst) multi_suspend && !exc.valid |=> exec_state[15:12] == $past(multi_next_reg);
    endproperty
    a_suspend_records: assert property (p_suspend_records) else $error("next register not recorded");

    property p_cont_zero;
        @(posedge clk) disable iff (rst) multi_suspend && !exc.valid |=> exec_state[26:25] == 2'h0
            && exec_state[11:10] == 2'h0;
    endproperty
    a_cont_zero: assert property (p_cont_zero) else $error("continuation form bits not zero");

    property p_resume_reg;
        @(posedge clk) disable iff (rst) multi_resume |=> resume_valid && resume_reg == $past(exec_state[15:12]);
    endproperty
    a_resume_reg: assert property (p_resume_reg) else $error("resume register mismatch");

    property p_t_fault;
        @(posedge clk) disable iff (rst) exec_issue && !exec_state[24] |=> t_fault;
    endproperty
    a_t_fault: assert property (p_t_fault) else $error("no fault with t bit clear");

    property p_t_only_cleared;
        @(posedge clk) disable iff (rst) $fell(exec_state[24]) |-> $past(t_clear_valid) || $past(exc_ret);
    endproperty
    a_t_only_cleared: assert property (p_t_only_cleared) else $error("t bit cleared without cause");

    property p_all_but_nmi_mask_exit;
        @(posedge clk) disable iff (rst) ret_nonnmi |=> !all_mask_q;
    endproperty
    a_all_but_nmi_mask_exit: assert property (p_all_but_nmi_mask_exit) else $error("fault mask kept on handler exit");

    property p_configurable_priority_mask_blocks;
        @(posedge clk) disable iff (rst) cfg_mask_q && req_configurable |=> exc_blocked;
    endproperty
    a_configurable_priority_mask_blocks: assert property (p_configurable_priority_mask_blocks) else $error("configurable exception not blocked");

    property p_all_but_nmi_mask_nmi;
        @(posedge clk) disable iff (rst) req_is_nmi && !req_configurable |=> !exc_blocked;
    endproperty
    a_all_but_nmi_mask_nmi: assert property (p_all_but_nmi_mask_nmi) else $error("nmi blocked");

    property p_base_priority_threshold;
        @(posedge clk) disable iff (rst) req_configurable && !cfg_mask_q && !all_mask_q
            |=> exc_blocked == ($past(base_thr_q) != 8'h00 && $past(req_priority) >= $past(base_thr_q));
    endproperty
    a_base_priority_threshold: assert property (p_base_priority_threshold) else $error("base priority threshold wrong");

    property p_handler_stack_select;
        @(posedge clk) disable iff (rst) wr_ct && handler_mode && !exc.valid |=> $stable(ctrl_q[1]);
    endproperty
    a_handler_stack_select: assert property (p_handler_stack_select) else $error("stack select written in handler");

    property p_return_psp;
        @(posedge clk) disable iff (rst) exc_ret
            |=> ctrl_q[1] == ($past(exc.ret_thread) && $past(exc.ret_proc_stack));
    endproperty
    a_return_psp: assert property (p_return_psp) else $error("stack select not set by return");

    property p_exec_reserved;
        @(posedge clk) disable iff (rst)
            1'b1 |-> exec_state[31:27] == 5'h00 && exec_state[23:16] == 8'h00 && exec_state[9:0] == 10'h000;
    endproperty
    a_exec_reserved: assert property (p_exec_reserved) else $error("exec reserved bits set");

    property p_cond_start;
        @(posedge clk) disable iff (rst) cond_blk_start && !multi_suspend && !exc.valid
            |=> exec_state[26:25] == $past(cond_blk_state[1:0]) && exec_state[15:10] == $past(cond_blk_state[7:2]);
    endproperty
    a_cond_start: assert property (p_cond_start) else $error("conditional state not loaded");

    property p_cond_len;
        @(posedge clk) disable iff (rst)
            1'b1 |-> cond_cnt_q <= `SSM_COND_LEN_MAX;
    endproperty
    a_cond_len: assert property (p_cond_len) else $error("conditional block too long");

    property p_base_bits;
        @(posedge clk) disable iff (rst) wr_bt
            |=> base_thr_q == ($past(sw_wr.data[7:0]) & PRIO_KEEP);
    endproperty
    a_base_bits: assert property (p_base_bits) else $error("base threshold write wrong");

    property p_fp_active;
        @(posedge clk) disable iff (rst) wr_ct && !exc.valid
            |=> ctrl_q[2] == $past(sw_wr.data[2]);
    endproperty
    a_fp_active: assert property (p_fp_active) else $error("fp context flag not written");

    property p_unpriv;
        @(posedge clk) disable iff (rst) wr_ct && !exc.valid
            |=> ctrl_q[0] == $past(sw_wr.data[0]);
    endproperty
    a_unpriv: assert property (p_unpriv) else $error("privilege bit not written");

    property p_entry_main;
        @(posedge clk) disable iff (rst) exc_entry
            |=> !ctrl_q[1];
    endproperty
    a_entry_main: assert property (p_entry_main) else $error("entry kept process stack");

    property p_reset_zero;
        @(posedge clk) $fell(rst)
            |-> !cfg_mask_q && !all_mask_q && base_thr_q == 8'h00 && ctrl_q == 3'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("masks not zero after reset");

    property p_unpriv_ignored;
        @(posedge clk) disable iff (rst) sw_wr.valid && !privileged && !exc.valid
            |=> $stable(cfg_mask_q) && $stable(all_mask_q) && $stable(base_thr_q) && $stable(ctrl_q);
    endproperty
    a_unpriv_ignored: assert property (p_unpriv_ignored) else $error("unprivileged write landed");

    property p_chg_state;
        @(posedge clk) disable iff (rst) chg_ok && chg_state_cfg_mask
            |=> cfg_mask_q == $past(chg_state_disable);
    endproperty
    a_chg_state: assert property (p_chg_state) else $error("change state did not set mask");

    property p_handler_hidden;
        @(posedge clk) disable iff (rst) handler_mode && sw_rd_sel == `SSM_SEL_CONTROL
            |=> !sw_rd_data[1];
    endproperty
    a_handler_hidden: assert property (p_handler_hidden) else $error("stack select visible in handler");

    property p_read_priv;
        @(posedge clk) disable iff (rst) !privileged
            |=> sw_rd_data == `SSM_ZERO32;
    endproperty
    a_read_priv: assert property (p_read_priv) else $error("unprivileged read not zero");

    c_suspend_resume: cover property (@(posedge clk) disable iff (rst) multi_suspend ##[1:20] multi_resume);
    c_it_block: cover property (@(posedge clk) disable iff (rst) cond_blk_start ##1 cond_blk_advance [*4]);
    c_chg_state: cover property (@(posedge clk) disable iff (rst) chg_ok && chg_state_all_mask);
    c_base_priority_threshold_block: cover property (@(posedge clk) disable iff (rst) bp_block && req_configurable);
    c_psp_switch: cover property (@(posedge clk) disable iff (rst) wr_ct && sw_wr.data[1] && !handler_mode);
endmodule
`default_nettype wire

// ===== dv/ssm_core_model.sv
// pipeline and exception controller stand-in that drives the block's core-side strobes
`default_nettype none
module ssm_core_model (
    input  wire logic              clk,
    output var  ssm_pkg::ssm_exc_t exc,
    output var  logic              multi_suspend,
    output var  logic [3:0]        multi_next_reg,
    output var  logic              multi_resume,
    output var  logic              t_clear_valid,
    output var  logic              t_clear_value,
    output var  logic              exec_issue
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        exc = '0;
        {multi_suspend, multi_resume, t_clear_valid, t_clear_value, exec_issue} = 5'h00;
        multi_next_reg = 4'h0;
    end
    // interrupt lands mid transfer: next operand handed over with the suspend strobe
    task automatic suspend(input logic [3:0] r);
        @(negedge clk);
        multi_suspend = 1'b1;
        multi_next_reg = r;
        @(negedge clk);
        multi_suspend = 1'b0;
        multi_next_reg = ~r;
    endtask
    // k: 2 resume, 1 issue, 0 compact bit load
    task automatic strobe(input int k, input logic v);
        @(negedge clk);
        {multi_resume, exec_issue, t_clear_valid} = 3'(1 << k);
        t_clear_value = v;
        @(negedge clk);
        {multi_resume, exec_issue, t_clear_valid} = 3'h0;
        t_clear_value = ~v;
    endtask
    // ret_thread and ret_psp go together; a handler-to-handler return passes psp low
    task automatic exc_event(input logic entry, input logic [8:0] num, input logic process_stack_pointer, input logic [31:0] st);
        @(negedge clk);
        exc = '{1'b1, entry, num, process_stack_pointer, process_stack_pointer, 1'b0, st};
        @(negedge clk);
        exc.valid = 1'b0;
        exc.status = ~st;
    endtask
endmodule
`default_nettype wire

// ===== dv/special_status_mask_control_regs_test.sv
// self-checking bench for the special status, mask and control registers
`default_nettype none
module special_status_mask_control_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic priv = 1'b1, hmode = 1'b0, cv = 1'b0, cd = 1'b0, cp = 1'b0, cf = 1'b0;
    logic cb_go = 1'b0, cb_adv = 1'b0, req_cfg = 1'b0, req_nmi = 1'b0;
    logic [7:0] cb_st = 8'h00, req_prio = 8'h00;
    logic [2:0] rd_sel = 3'h0;
    ssm_pkg::ssm_wr_t sw_wr = '0;
    ssm_pkg::ssm_exc_t exc;
    logic ms, mr, tv, tx, ei, rv, tf, blocked, use_ps, unpriv, fp_pres;
    logic [3:0] mn, rreg;
    logic [31:0] rd_data, xs;
    int errors = 0, checked = 0;
    always #20 clk = ~clk;
    ssm_core_model core (.clk(clk), .exc(exc), .multi_suspend(ms), .multi_next_reg(mn), .multi_resume(mr),
        .t_clear_valid(tv), .t_clear_value(tx), .exec_issue(ei));
    ssm_special_regs uut (.clk(clk), .rst(rst), .privileged(priv), .handler_mode(hmode), .sw_wr(sw_wr),
        .sw_rd_sel(rd_sel), .chg_state_valid(cv), .chg_state_disable(cd), .chg_state_cfg_mask(cp),
        .chg_state_all_mask(cf), .multi_suspend(ms), .multi_next_reg(mn), .multi_resume(mr),
        .cond_blk_start(cb_go), .cond_blk_state(cb_st), .cond_blk_advance(cb_adv), .t_clear_valid(tv),
        .t_clear_value(tx), .exec_issue(ei), .exc(exc), .req_priority(req_prio), .req_configurable(req_cfg),
        .req_is_nmi(req_nmi), .sw_rd_data(rd_data), .exec_state(xs), .resume_reg(rreg), .resume_valid(rv),
        .t_fault(tf), .exc_blocked(blocked), .use_process_stack(use_ps), .thread_unpriv_o(unpriv),
        .fp_preserve(fp_pres));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [2:0] s, input logic [31:0] v);
        @(negedge clk);
        sw_wr = '{1'b1, s, v};
        @(negedge clk);
        sw_wr = '{1'b0, ~s, ~v};
    endtask
    // read data is registered: select now, look one cycle on
    task automatic rd(input logic [2:0] s, input logic [31:0] exp);
        rd_sel = s;
        @(negedge clk);
        chk(rd_data, exp);
    endtask
    task automatic blk(input logic cfg, input logic nmi, input logic [7:0] pr, input logic e);
        {req_cfg, req_nmi, req_prio} = {cfg, nmi, pr};
        cyc(2);
        chk({31'h0, blocked}, {31'h0, e});
    endtask
    task automatic chg_st(input logic dis, input logic pm, input logic fm);
        @(negedge clk);
        {cv, cd, cp, cf} = {1'b1, dis, pm, fm};
        @(negedge clk);
        cv = 1'b0;
    endtask
    task automatic itp(input logic adv, input logic [7:0] st);
        @(negedge clk);
        {cb_go, cb_adv, cb_st} = {~adv, adv, st};
        @(negedge clk);
        {cb_go, cb_adv, cb_st} = {2'h0, ~st};
    endtask
    // a one-cycle pulse may land on either of the next edges, so look over a short bounded span
    task automatic see_pulse(input logic s, input logic e);
        logic hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            hit |= (s ? tf : rv) === 1'b1;
            @(negedge clk);
        end
        chk({31'h0, hit}, {31'h0, e});
    endtask
    task automatic t_reset;
        chk(xs, 32'h0100_0000);
        chk({29'h0, fp_pres, use_ps, unpriv}, 32'h0000_0000);
        for (int s = 0; s < 5; s++) rd(3'(s), 32'h0000_0000);
        wr(3'h0, 32'hffff_ffff);
        cyc(2);
        chk(xs, 32'h0100_0000);
    endtask
    task automatic t_masks;
        priv = 1'b0;
        wr(3'h1, 32'h0000_0001);
        rd(3'h1, 32'h0000_0000);
        priv = 1'b1;
        rd(3'h1, 32'h0000_0000);
        wr(3'h1, 32'hffff_ffff);
        rd(3'h1, 32'h0000_0001);
        blk(1'b1, 1'b0, 8'h00, 1'b1);
        blk(1'b0, 1'b0, 8'h00, 1'b0);
        chg_st(1'b0, 1'b1, 1'b0);
        blk(1'b1, 1'b0, 8'h00, 1'b0);
        chg_st(1'b1, 1'b0, 1'b1);
        blk(1'b0, 1'b0, 8'h00, 1'b1);
        blk(1'b0, 1'b1, 8'h00, 1'b0);
        core.exc_event(1'b0, 9'h002, 1'b0, 32'h0100_0000);
        rd(3'h2, 32'h0000_0001);
        core.exc_event(1'b0, 9'h003, 1'b0, 32'h0100_0000);
        rd(3'h2, 32'h0000_0000);
        wr(3'h3, 32'hffff_ff40);
        rd(3'h3, 32'h0000_0040);
        blk(1'b1, 1'b0, 8'h40, 1'b1);
        blk(1'b1, 1'b0, 8'h3f, 1'b0);
        wr(3'h3, 32'h0000_0000);
        blk(1'b1, 1'b0, 8'hff, 1'b0);
    endtask
    task automatic t_control;
        wr(3'h4, 32'hffff_ffff);
        rd(3'h4, 32'h0000_0007);
        cyc(2);
        chk({29'h0, fp_pres, use_ps, unpriv}, 32'h0000_0007);
        core.exc_event(1'b1, 9'h00f, 1'b0, 32'h0100_0000);
        hmode = 1'b1;
        wr(3'h4, 32'h0000_0002);
        rd(3'h4, 32'h0000_0000);
        core.exc_event(1'b0, 9'h00f, 1'b1, 32'h0100_0000);
        hmode = 1'b0;
        rd(3'h4, 32'h0000_0002);
        cyc(2);
        chk({31'h0, use_ps}, 32'h0000_0001);
    endtask
    task automatic t_exec;
        itp(1'b0, 8'hff);
        cyc(1);
        chk(xs & 32'h0600_fc00, 32'h0600_fc00);
        repeat (4) itp(1'b1, 8'h00);
        cyc(1);
        chk(xs & 32'h0600_fc00, 32'h0000_0000);
        itp(1'b0, 8'hff);
        core.suspend(4'h5);
        cyc(1);
        chk(xs & 32'h0600_fc00, 32'h0000_5000);
        core.strobe(2, 1'b0);
        see_pulse(1'b0, 1'b1);
        chk({28'h0, rreg}, 32'h0000_0005);
        core.strobe(0, 1'b1);
        core.strobe(1, 1'b0);
        see_pulse(1'b1, 1'b0);
        core.strobe(0, 1'b0);
        chk(xs & 32'h0100_0000, 32'h0000_0000);
        core.strobe(1, 1'b0);
        see_pulse(1'b1, 1'b1);
        core.exc_event(1'b0, 9'h003, 1'b0, 32'h0100_0000);
        chk(xs & 32'h0100_0000, 32'h0100_0000);
    endtask
    initial begin
        cyc(8);
        rst = 1'b0;
        t_reset();
        t_masks();
        t_control();
        t_exec();
        complete_run();
    end
endmodule
`default_nettype wire
